// file: verilog/gcps_defines.vh
// gcps_defines.vh: register map, field positions, reset values and timing
// constants of the dual-port capture status block.
// assumes inclusion by bare name from the design files only.
`ifndef GCPS_DEFINES_VH
`define GCPS_DEFINES_VH

// register byte addresses (word aligned)
`define GCPS_ADDR_PORTA_CFG 8'h00
`define GCPS_ADDR_PORTB_CFG 8'h04
`define GCPS_ADDR_PKT_CFG 8'h08
`define GCPS_ADDR_COMMAND 8'h0C
`define GCPS_ADDR_PORTA_STAT 8'h10
`define GCPS_ADDR_PORTB_STAT 8'h14
`define GCPS_ADDR_BITS 8

// port configuration fields
`define GCPS_PCFG_W 4
`define GCPS_PCFG_DIRECT 0
`define GCPS_PCFG_FACLOOP 1
`define GCPS_PCFG_EQLOOP 2
`define GCPS_PCFG_CAPON 3
`define GCPS_PCFG_DEFAULT 4'h9

// packet configuration fields
`define GCPS_SNAP_W 11
`define GCPS_PKT_SNAP_LSB 0
`define GCPS_PKT_VARLEN 16
`define GCPS_PKT_SESSION 17
`define GCPS_SNAP_DEFAULT 11'h600
`define GCPS_VARLEN_DEFAULT 1'h1
`define GCPS_SESSION_DEFAULT 1'h0
`define GCPS_SNAP_ALIGN_MASK 11'h7FC

// command fields (write-only, self clearing)
`define GCPS_CMD_DEFAULTS 0
`define GCPS_CMD_PHYRESET_A 1
`define GCPS_CMD_PHYRESET_B 2

// status fields
`define GCPS_ST_LOCALUP 0
`define GCPS_ST_PEERUP 1
`define GCPS_ST_SIGLOSS 2
`define GCPS_ST_FRAMELOSS 3
`define GCPS_ST_WORD_LSB 16
`define GCPS_WORD_W 16

// activity hold for the capture indicator
`define GCPS_CLK_HZ 50000000
`define GCPS_ACT_HOLD_MS 50

// ahb-lite encodings
`define GCPS_HTRANS_NONSEQ_BIT 1
`define GCPS_HRESP_OKAY 1'h0

`endif

// file: verilog/gcps_port_status.v
// gcps_port_status.v: ahb-lite register slave, per-port mode and loopback
// control, sticky link status, capture enable, record length and indicators.
// assumes one clk_sys domain; signal-detect and config-done come from pins,
// all pcs and packet inputs come from logic on clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "gcps_defines.vh"

// Operation
// - blue indicator lights once configuration has loaded, then stays lit.
// - capture indicator lit while session active and records are being produced.
// - each port's signal-detect indicator follows its optical receiver's valid signal.
// - link-down indicator: negotiation failed when direct, monitored link down when tapping.
// - direct-attach mode is the default after power-up.
// - direct-attach mode runs gigabit auto-negotiation with the partner.
// - tap mode: no negotiation, receive only unless facility loopback is on, one direction per port.
// - restore-defaults command returns every port setting to its default.
// - facility loopback sends received line data back out the transmitter.
// - equipment loopback turns transmit path back into receive path.
// - each port has its own capture enable; disabled ports make no records.
// - fixed mode pads records to snap length; variable mode gives shorter records.
// - at most snap length bytes are captured per packet, default 1536.
// - per-port status conditions latch until the next status read.
// - local link-up flag sets once negotiation reached a valid link when direct, on a code stream when tapping.
// - peer link-up flag sets when the partner reports its link up.
// - signal-loss flag sets whenever the receiver sees no valid signal.
// - framing-loss flag sets whenever no valid code stream is detected.
// - latest received negotiation config word is readable in port status.
module gcps_port_status #(
	parameter PORTS = 2,
	parameter LEN_W = 16,
	parameter ACT_HOLD_CYC = `GCPS_CLK_HZ / 1000 * `GCPS_ACT_HOLD_MS
) (
	// clock and reset
	input wire clk_sys,
	input wire rst,
	// ahb-lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	// pins from the board
	input wire configDone,
	input wire [PORTS-1:0] sigDetect,
	// pcs status, clk_sys domain
	input wire [PORTS-1:0] codeSync,
	input wire [PORTS-1:0] anLinkOk,
	input wire [PORTS-1:0] peerLinkUp,
	input wire [PORTS-1:0] cfgWordStrobe,
	input wire [PORTS*`GCPS_WORD_W-1:0] cfgWordIn,
	// phy control
	output reg [PORTS-1:0] anEnable,
	output reg [PORTS-1:0] txEnable,
	output reg [PORTS-1:0] facilityLoop,
	output reg [PORTS-1:0] equipLoop,
	output reg [PORTS-1:0] phyReset,
	// packet end events and records
	input wire [PORTS-1:0] pktEnd,
	input wire [PORTS*LEN_W-1:0] pktLen,
	output reg [PORTS-1:0] recValid,
	output reg [PORTS*LEN_W-1:0] recLen,
	output reg [PORTS*LEN_W-1:0] recDataLen,
	// indicators
	output reg ledConfigured,
	output reg ledCapture,
	output reg [PORTS-1:0] ledSigDetect,
	output reg [PORTS-1:0] ledLinkDown
);

	localparam [31:0] HOLD_CNT = ACT_HOLD_CYC;

	// zero wait state slave, always okay
	assign hreadyout = 1'b1;
	assign hresp = `GCPS_HRESP_OKAY;

	// address phase capture
	reg wrPend_r;
	reg [`GCPS_ADDR_BITS-1:0] wrAddr_r;
	wire addrPhase;
	wire rdTake;
	wire [`GCPS_ADDR_BITS-1:0] aLow;
	assign addrPhase = hsel & htrans[`GCPS_HTRANS_NONSEQ_BIT] & hready;
	assign rdTake = addrPhase & ~hwrite;
	assign aLow = haddr[`GCPS_ADDR_BITS-1:0];

	// write data arrives one cycle after its address phase
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wrPend_r <= 1'b0;
			wrAddr_r <= {`GCPS_ADDR_BITS{1'b0}};
		end else begin
			wrPend_r <= addrPhase & hwrite;
			wrAddr_r <= aLow;
		end
	end

	wire cmdWr;
	wire restoreDefaults;
	wire pktCfgWr;
	assign cmdWr = wrPend_r && (wrAddr_r == `GCPS_ADDR_COMMAND);
	assign restoreDefaults = cmdWr & hwdata[`GCPS_CMD_DEFAULTS];
	assign pktCfgWr = wrPend_r && (wrAddr_r == `GCPS_ADDR_PKT_CFG);

	// packet configuration register
	reg [`GCPS_SNAP_W-1:0] snapLen_r;
	reg varLen_r;
	reg sessionOn_r;
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			snapLen_r <= `GCPS_SNAP_DEFAULT;
			varLen_r <= `GCPS_VARLEN_DEFAULT;
			sessionOn_r <= `GCPS_SESSION_DEFAULT;
		end else if (restoreDefaults) begin
			snapLen_r <= `GCPS_SNAP_DEFAULT;
			varLen_r <= `GCPS_VARLEN_DEFAULT;
		end else if (pktCfgWr) begin
			// snap length kept word aligned, as records are
			snapLen_r <= hwdata[`GCPS_PKT_SNAP_LSB +: `GCPS_SNAP_W] & `GCPS_SNAP_ALIGN_MASK;
			varLen_r <= hwdata[`GCPS_PKT_VARLEN];
			sessionOn_r <= hwdata[`GCPS_PKT_SESSION];
		end
	end

	// pin synchronisers: first stage read only by the second
	reg cfgDoneMeta_r;
	reg cfgDoneSync_r;
	reg [PORTS-1:0] sigMeta_r;
	reg [PORTS-1:0] sigSync_r;
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cfgDoneMeta_r <= 1'b0;
			cfgDoneSync_r <= 1'b0;
			sigMeta_r <= {PORTS{1'b0}};
			sigSync_r <= {PORTS{1'b0}};
		end else begin
			cfgDoneMeta_r <= configDone;
			cfgDoneSync_r <= cfgDoneMeta_r;
			sigMeta_r <= sigDetect;
			sigSync_r <= sigMeta_r;
		end
	end

	// per-port state
	reg [`GCPS_PCFG_W-1:0] portCfg_r [0:PORTS-1];
	reg [3:0] sticky_r [0:PORTS-1];
	reg [`GCPS_WORD_W-1:0] cfgWord_r [0:PORTS-1];
	wire [PORTS-1:0] localUp;
	wire [PORTS-1:0] recFire;

	genvar p;
	generate
		for (p = 0; p < PORTS; p = p + 1) begin : gPort
			wire cfgWr;
			wire statRd;
			wire direct;
			wire [3:0] cond;
			wire [LEN_W-1:0] inLen;
			wire [LEN_W-1:0] snapWide;
			wire [LEN_W-1:0] capLen;
			assign cfgWr = wrPend_r && (wrAddr_r == (`GCPS_ADDR_PORTA_CFG + 8'h04 * p));
			assign statRd = rdTake && (aLow == (`GCPS_ADDR_PORTA_STAT + 8'h04 * p));
			assign direct = portCfg_r[p][`GCPS_PCFG_DIRECT];
			// direct: negotiated link; tap: monitored link carries a code stream
			assign localUp[p] = direct ? anLinkOk[p] : codeSync[p];
			assign cond[`GCPS_ST_LOCALUP] = localUp[p];
			assign cond[`GCPS_ST_PEERUP] = peerLinkUp[p];
			assign cond[`GCPS_ST_SIGLOSS] = ~sigSync_r[p];
			assign cond[`GCPS_ST_FRAMELOSS] = ~codeSync[p];

			// port configuration, restore wins over a plain write
			always @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					portCfg_r[p] <= `GCPS_PCFG_DEFAULT;
				end else if (restoreDefaults) begin
					portCfg_r[p] <= `GCPS_PCFG_DEFAULT;
				end else if (cfgWr) begin
					portCfg_r[p] <= hwdata[`GCPS_PCFG_W-1:0];
				end
			end

			// sticky flags: a read clears, a present condition sets (set wins)
			always @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					sticky_r[p] <= 4'h0;
				end else if (statRd) begin
					sticky_r[p] <= cond;
				end else begin
					sticky_r[p] <= sticky_r[p] | cond;
				end
			end

			// latest config word from the partner
			always @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					cfgWord_r[p] <= {`GCPS_WORD_W{1'b0}};
				end else if (cfgWordStrobe[p]) begin
					cfgWord_r[p] <= cfgWordIn[p*`GCPS_WORD_W +: `GCPS_WORD_W];
				end
			end

			// phy controls and indicators
			always @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					anEnable[p] <= 1'b0;
					txEnable[p] <= 1'b0;
					facilityLoop[p] <= 1'b0;
					equipLoop[p] <= 1'b0;
					phyReset[p] <= 1'b0;
					ledSigDetect[p] <= 1'b0;
					ledLinkDown[p] <= 1'b1;
				end else begin
					anEnable[p] <= direct;
					// tap mode is receive only unless chaining through the loop
					txEnable[p] <= direct | portCfg_r[p][`GCPS_PCFG_FACLOOP];
					facilityLoop[p] <= portCfg_r[p][`GCPS_PCFG_FACLOOP];
					equipLoop[p] <= portCfg_r[p][`GCPS_PCFG_EQLOOP];
					phyReset[p] <= cmdWr & hwdata[`GCPS_CMD_PHYRESET_A + p];
					ledSigDetect[p] <= sigSync_r[p];
					ledLinkDown[p] <= ~localUp[p];
				end
			end

			// record length: truncate to snap, pad to snap in fixed mode
			assign inLen = pktLen[p*LEN_W +: LEN_W];
			assign snapWide = {{(LEN_W-`GCPS_SNAP_W){1'b0}}, snapLen_r};
			assign capLen = (inLen > snapWide) ? snapWide : inLen;
			assign recFire[p] = pktEnd[p] & portCfg_r[p][`GCPS_PCFG_CAPON] & sessionOn_r;
			always @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					recValid[p] <= 1'b0;
					recLen[p*LEN_W +: LEN_W] <= {LEN_W{1'b0}};
					recDataLen[p*LEN_W +: LEN_W] <= {LEN_W{1'b0}};
				end else begin
					recValid[p] <= recFire[p];
					if (recFire[p]) begin
						recDataLen[p*LEN_W +: LEN_W] <= capLen;
						recLen[p*LEN_W +: LEN_W] <= varLen_r ? capLen : snapWide;
					end
				end
			end
		end
	endgenerate

	// capture activity stretch so single records stay visible
	reg [31:0] actCnt_r;
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			actCnt_r <= 32'h0;
		end else if (|recFire) begin
			actCnt_r <= HOLD_CNT;
		end else if (actCnt_r != 32'h0) begin
			actCnt_r <= actCnt_r - 32'h1;
		end
	end

	// global indicators; configured stays lit once seen
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ledConfigured <= 1'b0;
			ledCapture <= 1'b0;
		end else begin
			ledConfigured <= ledConfigured | cfgDoneSync_r;
			ledCapture <= sessionOn_r && (actCnt_r != 32'h0);
		end
	end

	// read data registered at the address phase edge
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			hrdata <= 32'h0;
		end else if (rdTake) begin
			if (aLow == `GCPS_ADDR_PORTA_CFG) begin
				hrdata <= {28'h0, portCfg_r[0]};
			end else if (aLow == `GCPS_ADDR_PORTB_CFG) begin
				hrdata <= {28'h0, portCfg_r[1]};
			end else if (aLow == `GCPS_ADDR_PKT_CFG) begin
				hrdata <= {14'h0, sessionOn_r, varLen_r, 5'h0, snapLen_r};
			end else if (aLow == `GCPS_ADDR_PORTA_STAT) begin
				hrdata <= {cfgWord_r[0], 12'h0, sticky_r[0]};
			end else if (aLow == `GCPS_ADDR_PORTB_STAT) begin
				hrdata <= {cfgWord_r[1], 12'h0, sticky_r[1]};
			end else begin
				hrdata <= 32'h0; // unmapped and command read as zero
			end
		end
	end

endmodule
`default_nettype wire

// file: bench/gcps_checker.sv
// gcps_checker.sv: port-level checks on the capture status block.
// assumes one clk_sys domain and binding onto gcps_port_status.
`timescale 1ns/1ps
`default_nettype none
module gcps_checker #(
	parameter int ACT_HOLD_CYC = 8
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// line side
	input wire logic configDone,
	input wire logic [1:0] sigDetect,
	input wire logic [1:0] anLinkOk,
	input wire logic [1:0] pktEnd,
	input wire logic [31:0] pktLen,
	// block outputs
	input wire logic [1:0] anEnable,
	input wire logic [1:0] recValid,
	input wire logic [31:0] recLen,
	input wire logic [31:0] recDataLen,
	input wire logic ledConfigured,
	input wire logic ledCapture,
	input wire logic [1:0] ledSigDetect,
	input wire logic [1:0] ledLinkDown
);
	int idleCnt_r;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// cycles since the last record, saturating so it never wraps
	always_ff @(posedge clk_sys or posedge rst)
		if (rst) idleCnt_r <= 100000;
		else if (recValid != 2'b00) idleCnt_r <= 0;
		else if (idleCnt_r < 100000) idleCnt_r <= idleCnt_r + 1;
	// lamps and records against their causes
	AST_LINK_DOWN: assert property (anEnable[0] && $past(anEnable[0])
		|-> ledLinkDown[0] == !$past(anLinkOk[0])) else $error("link lamp wrong");
	AST_REC_AFTER_END: assert property (recValid[0] |-> $past(pktEnd[0]))
		else $error("record without packet end");
	AST_REC_SNAP: assert property (recValid[1] |-> recDataLen[31:16] <= $past(pktLen[31:16])
		&& recDataLen[31:16] <= recLen[31:16]) else $error("record too long");
	AST_SIG_LAMP: assert property ($stable(sigDetect) [*4] |=> ledSigDetect == $past(sigDetect))
		else $error("signal lamp wrong");
	AST_CFG_ON: assert property (configDone [*3] |=> ledConfigured)
		else $error("config lamp late");
	AST_CFG_HOLD: assert property (ledConfigured |=> ledConfigured)
		else $error("config lamp dropped");
	AST_CAP_ON: assert property (recValid != 2'b00 |-> ##[0:2] ledCapture)
		else $error("capture lamp off");
	AST_CAP_OFF: assert property (idleCnt_r > ACT_HOLD_CYC + 2 |-> !ledCapture)
		else $error("capture lamp stuck");
	// main scenarios reached
	cover property (recValid[0]);
	cover property (recValid[1]);
	cover property ($fell(ledLinkDown[0]));
endmodule
bind gcps_port_status gcps_checker #(.ACT_HOLD_CYC(ACT_HOLD_CYC)) i_gcps_checker (.clk_sys,
	.rst, .configDone, .sigDetect, .anLinkOk, .pktEnd, .pktLen, .anEnable, .recValid, .recLen,
	.recDataLen, .ledConfigured, .ledCapture, .ledSigDetect, .ledLinkDown);
`default_nettype wire

// file: bench/gcps_link_partner.sv
// gcps_link_partner.sv: far end of both ports: optics, pcs state, word, packets.
// assumes the bench drives its controls at posedge by non-blocking writes.
`timescale 1ns/1ps
`default_nettype none
module gcps_link_partner (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// bench controls
	input wire logic [1:0] lightOn,
	input wire logic [1:0] linkOn,
	input wire logic [1:0] sendPkt,
	input wire logic [15:0] lenIn,
	input wire logic [15:0] wordIn,
	// towards the block
	output logic [1:0] sigDetect,
	output logic [1:0] codeSync,
	output logic [1:0] anLinkOk,
	output logic [1:0] peerLinkUp,
	output logic [1:0] cfgWordStrobe,
	output logic [31:0] cfgWordIn,
	output logic [1:0] pktEnd,
	output logic [31:0] pktLen
);
	// word and length are junk while no port strobes, so stale values never pass
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			{sigDetect, codeSync, anLinkOk, peerLinkUp, cfgWordStrobe, pktEnd} <= '0;
			cfgWordIn <= '0;
			pktLen <= '0;
		end else begin
			sigDetect <= lightOn;
			codeSync <= lightOn;
			anLinkOk <= lightOn & linkOn;
			peerLinkUp <= lightOn & linkOn;
			cfgWordStrobe <= lightOn & linkOn;
			cfgWordIn <= (lightOn & linkOn) != 0 ? {wordIn, wordIn} : ~cfgWordIn;
			pktEnd <= sendPkt;
			pktLen <= sendPkt != 0 ? {lenIn, lenIn} : ~pktLen;
		end
	end
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// tb_top.sv: self-checking bench: bus, random records, loops, status, lamps.
// assumes gcps_defines.vh on the include path of the design.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) check(n, 32'(e), 32'(g))
module tb_top;
	logic clk_sys = 0, rst = 1, hsel = 0, hwrite = 0, configDone = 0;
	logic [3:0] i_m [4] = '{4'h8, 4'h3, 4'h5, 4'h9};
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, recLen, recDataLen, cfgWordIn, pktLen;
	logic [1:0] htrans = 0, lightOn = 0, linkOn = 0, sendPkt = 0, sigDetect, codeSync;
	logic [1:0] anLinkOk, peerLinkUp, cfgWordStrobe, pktEnd, anEnable, txEnable, phyReset;
	logic [1:0] facilityLoop, equipLoop, recValid, ledSigDetect, ledLinkDown;
	logic [15:0] lenIn = 0, wordIn = 16'h41A0;
	logic hreadyout, hresp, ledConfigured, ledCapture;
	int fails = 0, nCompared = 0, cyc = 0, len, snap = 1536, vl = 1;
	gcps_link_partner i_gcps_link_partner (.clk_sys, .rst, .lightOn, .linkOn, .sendPkt,
		.lenIn, .wordIn, .sigDetect, .codeSync, .anLinkOk, .peerLinkUp, .cfgWordStrobe,
		.cfgWordIn, .pktEnd, .pktLen);
	gcps_port_status #(.ACT_HOLD_CYC(8)) i_gcps_port_status (.clk_sys, .rst, .hsel, .haddr,
		.htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.configDone, .sigDetect, .codeSync, .anLinkOk, .peerLinkUp, .cfgWordStrobe, .cfgWordIn,
		.anEnable, .txEnable, .facilityLoop, .equipLoop, .phyReset, .pktEnd, .pktLen,
		.recValid, .recLen, .recDataLen, .ledConfigured, .ledCapture, .ledSigDetect,
		.ledLinkDown);
	always #10 clk_sys = ~clk_sys;
	task automatic report_and_stop;
		if (fails == 0 && nCompared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic check(input string n, input logic [31:0] e, g);
		nCompared++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask
	// padded records are snap long, variable ones clipped to snap
	function automatic int expLen(input int l, input int pad);
		return pad ? snap : (l < snap ? l : snap);
	endfunction
	// single word transfer, each phase held until hreadyout is seen high
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		hsel <= 1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	// one packet end on port p, record looked at one cycle after the event
	task automatic pkt(input int p, input int l, input logic on);
		@(posedge clk_sys);
		sendPkt <= 2'(1 << p);
		lenIn <= 16'(l);
		@(posedge clk_sys);
		sendPkt <= 0;
		@(posedge clk_sys);
		@(negedge clk_sys);
		`CHK("recValid", on, recValid[p]);
		if (on) begin
			`CHK("recDataLen", expLen(l, 0), recDataLen[16*p +: 16]);
			`CHK("recLen", expLen(l, !vl), recLen[16*p +: 16]);
			// lamp is registered one edge after the record pulse
			@(negedge clk_sys);
			`CHK("ledCapture", 1, ledCapture);
		end
	endtask
	// hang guard
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc > 20000) begin
			fails++;
			report_and_stop();
		end
	end
	initial begin
		void'($urandom(41));
		repeat (5) @(posedge clk_sys);
		rst <= 0;
		configDone <= 1;
		lightOn <= 2'b11;
		ahb(1, 8'h40, 32'h0);
		ahb(0, 8'h40, 0); `CHK("unmapped", 0, rd);
		ahb(0, 8'h00, 0); `CHK("cfgA", 32'h9, rd);
		ahb(0, 8'h04, 0); `CHK("cfgB", 32'h9, rd);
		ahb(0, 8'h08, 0); `CHK("pktCfg", 32'h10600, rd);
		linkOn <= 2'b01;
		repeat (10) @(posedge clk_sys);
		@(negedge clk_sys);
		`CHK("anEnable", 2'b11, anEnable);
		`CHK("ledConfigured", 1, ledConfigured);
		`CHK("ledSigDetect", 2'b11, ledSigDetect);
		`CHK("ledLinkDown", 2'b10, ledLinkDown);
		ahb(0, 8'h10, 0);
		ahb(0, 8'h10, 0); `CHK("statA", 32'h41A00003, rd);
		lightOn <= 2'b10;
		repeat (3) @(posedge clk_sys);
		lightOn <= 2'b11;
		repeat (8) @(posedge clk_sys);
		ahb(0, 8'h10, 0); `CHK("statA", 32'h41A0000F, rd);
		ahb(0, 8'h10, 0); `CHK("statA", 32'h41A00003, rd);
		for (int i = 0; i < 24; i++) begin
			snap = i == 2 ? 16 : ($urandom % 381 + 4) * 4;
			vl = $urandom % 2;
			ahb(1, 8'h08, 32'h20000 | (vl << 16) | snap);
			len = i < 2 ? snap - i : $urandom % 2000 + 1;
			pkt(i % 2, len, 1);
		end
		repeat (14) @(posedge clk_sys);
		@(negedge clk_sys);
		`CHK("ledCapture", 0, ledCapture);
		linkOn <= 2'b00;
		foreach (i_m[k]) begin
			ahb(1, 8'h00, i_m[k]);
			repeat (3) @(posedge clk_sys);
			@(negedge clk_sys);
			`CHK("modeA", {i_m[k][0], |i_m[k][1:0], i_m[k][2:0]}, {ledLinkDown[0], txEnable[0], equipLoop[0], facilityLoop[0], anEnable[0]});
		end
		ahb(1, 8'h04, 32'h1);
		pkt(1, 64, 0); // disabled port stays silent
		pkt(0, 64, 1);
		ahb(1, 8'h0C, 32'h7);
		@(negedge clk_sys);
		`CHK("phyReset", 2'b11, phyReset);
		ahb(0, 8'h04, 0); `CHK("cfgB", 32'h9, rd);
		ahb(0, 8'h08, 0); `CHK("pktCfg", 32'h30600, rd);
		snap = 1536;
		vl = 1;
		pkt(1, 2000, 1);
		ahb(1, 8'h08, 32'h10600);
		pkt(0, 64, 0); // session off gives no records
		report_and_stop();
	end
endmodule
`default_nettype wire
